//--- bench/removed_port_pin_readback_tb.sv
module removed_port_pin_readback_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [3:0][7:0] RM = removed_pin_pkg::REMOVED_MASK;
    localparam logic [3:0][7:0] FO = removed_pin_pkg::FORCED_ONES;
    localparam logic [3:0][7:0] FS = removed_pin_pkg::FSEL_FORCED;
    logic clk_sys, sys_rst, adc_start, adc_core_valid, adc_done;
    logic [7:0] port_zero_pins, port_zero_pin_input;
    logic [3:0][7:0] port_pins, latch_write_data, direction_write_data, fsel_write_data;
    logic [3:0] latch_write, direction_write, fsel_write;
    logic [2:0] adc_channel;
    logic [9:0] adc_core_result, adc_result, m_res, cr;
    logic [3:0][7:0] pin_input, output_latch, direction, function_select, m_latch, m_dir, m_fsel;
    logic cv;
    integer seed = 32'h6c3f;
    int miscompares = 0;
    int num_checks = 0;
    removed_port_pin_readback u_dut (.clk_sys, .sys_rst, .port_zero_pins, .port_pins,
        .latch_write, .latch_write_data, .direction_write, .direction_write_data,
        .fsel_write, .fsel_write_data, .adc_start, .adc_channel, .adc_core_valid,
        .adc_core_result, .port_zero_pin_input, .pin_input, .output_latch, .direction,
        .function_select, .adc_result, .adc_done);
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_adc(input logic [10:0] got, input logic [10:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // write model: absent bits keep their forced value whatever the data
    function automatic logic [3:0][7:0] upd(input logic [3:0] we, input logic [3:0][7:0] d,
        input logic [3:0][7:0] cur, input logic [3:0][7:0] f);
        logic [3:0][7:0] r;
        r = cur;
        for (int p = 0; p < 4; p++) begin
            if (we[p]) begin
                r[p] = (d[p] & ~RM[p]) | (f[p] & RM[p]);
            end
        end
        return r;
    endfunction
    task automatic check_regs;
        chk_reg(output_latch, m_latch);
        chk_reg(direction, m_dir);
        chk_reg(function_select, m_fsel);
    endtask
    initial begin
        #(100 * 10000);
        miscompares++;
        end_sim;
    end
    initial begin
        {sys_rst, adc_start, adc_core_valid, adc_channel, adc_core_result} = 16'h8000;
        {latch_write, direction_write, fsel_write, port_zero_pins, port_pins} = 52'h0;
        {latch_write_data, direction_write_data, fsel_write_data} = 96'h0;
        m_latch = 32'hffffffff;
        m_dir = 32'hffffffff;
        m_fsel = FS;
        m_res = 10'h000;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(negedge clk_sys);
        check_regs;
        chk_reg(pin_input, FO);
        // back-to-back random writes, random strobes, last step idle
        for (int i = 0; i <= 200; i++) begin
            @(posedge clk_sys);
            m_latch = upd(latch_write, latch_write_data, m_latch, FO);
            m_dir = upd(direction_write, direction_write_data, m_dir, FO);
            m_fsel = upd(fsel_write, fsel_write_data, m_fsel, FS);
            latch_write <= (i < 200) ? 4'($random(seed)) : 4'h0;
            direction_write <= (i < 200) ? 4'($random(seed)) : 4'h0;
            fsel_write <= (i < 200) ? 4'($random(seed)) : 4'h0;
            latch_write_data <= $random(seed);
            direction_write_data <= $random(seed);
            fsel_write_data <= $random(seed);
            @(negedge clk_sys);
            check_regs;
        end
        // pins held over the three-edge read path
        for (int i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            port_pins <= $random(seed);
            port_zero_pins <= 8'($random(seed));
            repeat (3) @(posedge clk_sys);
            @(negedge clk_sys);
            chk_reg(pin_input, (port_pins & ~RM) | FO);
            chk_reg(port_zero_pin_input, port_zero_pins & 8'hfc);
        end
        // every channel; tied channel one must beat a simultaneous core result
        for (int c = 0; c < 8; c++) begin
            cv = c[1] ^ c[0];
            cr = 10'($random(seed));
            @(posedge clk_sys);
            adc_start <= 1'b1;
            adc_channel <= c[2:0];
            adc_core_valid <= cv;
            adc_core_result <= cr;
            @(posedge clk_sys);
            adc_start <= 1'b0;
            adc_core_valid <= 1'b0;
            @(negedge clk_sys);
            if (c < 2 || cv) begin
                m_res = (c < 2) ? 10'h3ff : cr;
            end
            chk_adc({adc_done, adc_result}, {(c < 2 || cv), m_res});
            @(negedge clk_sys);
            chk_adc({adc_done, adc_result}, {1'b0, m_res});
        end
        // core result alone, with no start in the same cycle
        cr = 10'($random(seed));
        @(posedge clk_sys);
        adc_core_valid <= 1'b1;
        adc_core_result <= cr;
        @(posedge clk_sys);
        adc_core_valid <= 1'b0;
        @(negedge clk_sys);
        chk_adc({adc_done, adc_result}, {1'b1, cr});
        @(negedge clk_sys);
        chk_adc({adc_done, adc_result}, {1'b0, cr});
        end_sim;
    end
endmodule // removed_port_pin_readback_tb

//--- core/removed_pin_pkg.sv
package removed_pin_pkg;

    // indices of the reduced ports inside the packed port arrays
    localparam int PORT_COUNT = 4;
    localparam int PORT_ONE = 0;
    localparam int PORT_TWO = 1;
    localparam int PORT_FIVE = 2;
    localparam int PORT_SIX = 3;

    localparam int PORT_WIDTH = 8;
    localparam int ADC_WIDTH = 10;
    localparam int CHANNEL_WIDTH = 3;

    // bits whose pins are absent, one byte per reduced port
    localparam logic [3:0][7:0] REMOVED_MASK = {8'h0c, 8'h82, 8'h28, 8'hf0};
    // forced value of pin input, output latch and direction on absent bits
    localparam logic [3:0][7:0] FORCED_ONES = {8'h0c, 8'h82, 8'h28, 8'hf0};
    // forced value of the function select on absent bits
    localparam logic [3:0][7:0] FSEL_FORCED = {8'h00, 8'h80, 8'h00, 8'h00};

    // port zero digital inputs tied low on bits 0 and 1
    localparam logic [7:0] PORT_ZERO_TIED_MASK = 8'h03;

    // reset values of the stored bits that still have pins
    localparam logic [7:0] LATCH_RESET = 8'hff;
    localparam logic [7:0] DIRECTION_RESET = 8'hff;
    localparam logic [7:0] FSEL_RESET = 8'h00;
    localparam logic [7:0] PIN_RESET = 8'h00;

    localparam logic [9:0] ADC_FULL_SCALE = 10'h3ff;
    localparam logic [2:0] ANALOG_CHANNEL_ZERO = 3'h0;
    localparam logic [2:0] ANALOG_CHANNEL_ONE = 3'h1;

    typedef struct packed {
        logic [7:0] p0_sync1;
        logic [7:0] p0_sync2;
        logic [7:0] p0_pin;
        logic [3:0][7:0] pin_sync1;
        logic [3:0][7:0] pin_sync2;
        logic [3:0][7:0] pin;
        logic [3:0][7:0] latch;
        logic [3:0][7:0] direction;
        logic [3:0][7:0] fsel;
        logic [9:0] adc_result;
        logic adc_done;
    } port_state_t;

endpackage

//--- core/removed_port_pin_readback.sv
// Behaviour
// - A conversion started on analog channel zero or one returns full scale 3ffh.
// - Port zero bits zero and one always read zero on the digital input.
// - Port one bits 4 to 7 read one in pin, latch and direction and zero in function select.
// - Port two bits 3 and 5 read one in pin, latch and direction and zero in function select.
// - Port five bits 1 and 7 read one in pin, latch and direction; function select bit 1 zero, bit 7 one.
// - Port six bits 2 and 3 read one in pin, latch and direction and zero in function select.
// - Writes to hard-wired bits leave their read-back unchanged while other bits take the data.
module removed_port_pin_readback (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] port_zero_pins,
    input wire logic [3:0][7:0] port_pins,
    input wire logic [3:0] latch_write,
    input wire logic [3:0][7:0] latch_write_data,
    input wire logic [3:0] direction_write,
    input wire logic [3:0][7:0] direction_write_data,
    input wire logic [3:0] fsel_write,
    input wire logic [3:0][7:0] fsel_write_data,
    input wire logic adc_start,
    input wire logic [2:0] adc_channel,
    input wire logic adc_core_valid,
    input wire logic [9:0] adc_core_result,
    output logic [7:0] port_zero_pin_input,
    output logic [3:0][7:0] pin_input,
    output logic [3:0][7:0] output_latch,
    output logic [3:0][7:0] direction,
    output logic [3:0][7:0] function_select,
    output logic [9:0] adc_result,
    output logic adc_done
);

    removed_pin_pkg::port_state_t state;
    removed_pin_pkg::port_state_t next_state;

    // keeps the bits with pins, substitutes the hard-wired value elsewhere
    function automatic logic [7:0] force_bits(input logic [7:0] value,
                                              input logic [7:0] mask,
                                              input logic [7:0] forced);
        force_bits = (value & ~mask) | (forced & mask);
    endfunction

    always_comb begin
        next_state = state;
        // two flops before the pins are read; second stage feeds the read-back
        next_state.p0_sync1 = port_zero_pins;
        next_state.p0_sync2 = state.p0_sync1;
        next_state.p0_pin = state.p0_sync2 & ~removed_pin_pkg::PORT_ZERO_TIED_MASK;
        next_state.pin_sync1 = port_pins;
        next_state.pin_sync2 = state.pin_sync1;
        for (int i = 0; i < removed_pin_pkg::PORT_COUNT; i++) begin
            next_state.pin[i] = force_bits(state.pin_sync2[i],
                removed_pin_pkg::REMOVED_MASK[i], removed_pin_pkg::FORCED_ONES[i]);
            if (latch_write[i]) begin
                next_state.latch[i] = force_bits(latch_write_data[i],
                    removed_pin_pkg::REMOVED_MASK[i], removed_pin_pkg::FORCED_ONES[i]);
            end
            if (direction_write[i]) begin
                next_state.direction[i] = force_bits(direction_write_data[i],
                    removed_pin_pkg::REMOVED_MASK[i], removed_pin_pkg::FORCED_ONES[i]);
            end
            if (fsel_write[i]) begin
                next_state.fsel[i] = force_bits(fsel_write_data[i],
                    removed_pin_pkg::REMOVED_MASK[i], removed_pin_pkg::FSEL_FORCED[i]);
            end
        end
        // tied channels full scale; a start on channel zero or one wins over a core result in the same cycle
        next_state.adc_done = 1'b0;
        if (adc_start && (adc_channel == removed_pin_pkg::ANALOG_CHANNEL_ZERO ||
                          adc_channel == removed_pin_pkg::ANALOG_CHANNEL_ONE)) begin
            next_state.adc_result = removed_pin_pkg::ADC_FULL_SCALE;
            next_state.adc_done = 1'b1;
        end else if (adc_core_valid) begin
            next_state.adc_result = adc_core_result;
            next_state.adc_done = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state.p0_sync1 <= removed_pin_pkg::PIN_RESET;
            state.p0_sync2 <= removed_pin_pkg::PIN_RESET;
            state.p0_pin <= removed_pin_pkg::PIN_RESET;
            for (int i = 0; i < removed_pin_pkg::PORT_COUNT; i++) begin
                state.pin_sync1[i] <= removed_pin_pkg::PIN_RESET;
                state.pin_sync2[i] <= removed_pin_pkg::PIN_RESET;
                // forced bits hold their value even during reset
                state.pin[i] <= force_bits(removed_pin_pkg::PIN_RESET,
                    removed_pin_pkg::REMOVED_MASK[i], removed_pin_pkg::FORCED_ONES[i]);
                state.latch[i] <= force_bits(removed_pin_pkg::LATCH_RESET,
                    removed_pin_pkg::REMOVED_MASK[i], removed_pin_pkg::FORCED_ONES[i]);
                state.direction[i] <= force_bits(removed_pin_pkg::DIRECTION_RESET,
                    removed_pin_pkg::REMOVED_MASK[i], removed_pin_pkg::FORCED_ONES[i]);
                state.fsel[i] <= force_bits(removed_pin_pkg::FSEL_RESET,
                    removed_pin_pkg::REMOVED_MASK[i], removed_pin_pkg::FSEL_FORCED[i]);
            end
            state.adc_result <= 10'h000;
            state.adc_done <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign port_zero_pin_input = state.p0_pin;
    assign pin_input = state.pin;
    assign output_latch = state.latch;
    assign direction = state.direction;
    assign function_select = state.fsel;
    assign adc_result = state.adc_result;
    assign adc_done = state.adc_done;

    tied_channel_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        adc_start && adc_channel < 3'h2 |=> adc_done && adc_result == 10'h3ff)
        else $error("tied channel did not return full scale");

    port_zero_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        port_zero_pin_input[1:0] == 2'h0)
        else $error("port zero tied bits not zero");

    port_one_forced_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pin_input[0][7:4] == 4'hf && output_latch[0][7:4] == 4'hf &&
        direction[0][7:4] == 4'hf && function_select[0][7:4] == 4'h0)
        else $error("port one hard-wired bits wrong");

    port_two_forced_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pin_input[1][3] && pin_input[1][5] && output_latch[1][3] && output_latch[1][5] &&
        direction[1][3] && direction[1][5] && !function_select[1][3] &&
        !function_select[1][5])
        else $error("port two hard-wired bits wrong");

    port_five_forced_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pin_input[2][1] && pin_input[2][7] && output_latch[2][1] && output_latch[2][7] &&
        direction[2][1] && direction[2][7] && !function_select[2][1] &&
        function_select[2][7])
        else $error("port five hard-wired bits wrong");

    port_six_forced_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pin_input[3][3:2] == 2'h3 && output_latch[3][3:2] == 2'h3 &&
        direction[3][3:2] == 2'h3 && function_select[3][3:2] == 2'h0)
        else $error("port six hard-wired bits wrong");

    forced_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        fsel_write[2] |=> function_select[2] ==
        ((($past(fsel_write_data[2]) & 8'h7d)) | 8'h80))
        else $error("write reached a hard-wired bit");

    present_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        latch_write[0] |=> output_latch[0][3:0] == $past(latch_write_data[0][3:0]))
        else $error("present latch bits did not take the write");

    present_pin_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ##3 pin_input[1][0] == $past(port_pins[1][0], 3))
        else $error("present pin not passed through");

    direction_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !direction_write[3] |=> $stable(direction[3]))
        else $error("direction changed without a write");

    latch_forced_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        latch_write[1] |=> output_latch[1] ==
        (($past(latch_write_data[1]) & 8'hd7) | 8'h28))
        else $error("latch write reached a hard-wired bit");

    direction_forced_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        direction_write[3] |=> direction[3] ==
        (($past(direction_write_data[3]) & 8'hf3) | 8'h0c))
        else $error("direction write reached a hard-wired bit");

    fsel_present_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        fsel_write[0] |=> function_select[0][3:0] == $past(fsel_write_data[0][3:0]))
        else $error("present select bits did not take the write");

    port_zero_pass_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ##3 port_zero_pin_input[7:2] == $past(port_zero_pins[7:2], 3))
        else $error("port zero present pins not passed through");

    latch_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !latch_write[2] |=> $stable(output_latch[2]))
        else $error("latch changed without a write");

    idle_no_done_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !adc_start && !adc_core_valid |=> !adc_done)
        else $error("conversion done without a request");

    result_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !(adc_start && adc_channel < 3'h2) && !adc_core_valid |=> $stable(adc_result))
        else $error("conversion result changed without an answer");

    core_result_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        adc_core_valid && !(adc_start && adc_channel < 3'h2) |=>
        adc_done && adc_result == $past(adc_core_result))
        else $error("core result not passed through");

    tied_start_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        adc_start && adc_channel == 3'h1);
    core_result_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        adc_core_valid && !adc_start);
    forced_write_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        latch_write[0] && latch_write_data[0][7:4] == 4'h0);
    fsel_five_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        fsel_write[2] && !fsel_write_data[2][7]);
    tied_clash_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        adc_start && adc_channel == 3'h1 && adc_core_valid);

endmodule // removed_port_pin_readback
